// ---- design/cmd_upper_pkg.sv ----
// constants and types for the upper command bits of the primary interface
// assumes byte-addressed, dword-aligned configuration accesses
package cmd_upper_pkg;

    // ------------------------------------------------------------
    // configuration map
    // ------------------------------------------------------------
    localparam logic [7:0]  CMD_OFFSET      = 8'h04;
    localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;

    // ------------------------------------------------------------
    // command field positions
    // ------------------------------------------------------------
    localparam int PAL_SNOOP_BIT   = 5;
    localparam int PARITY_RESP_BIT = 6;
    localparam int WAIT_CTL_BIT    = 7;
    localparam int SERR_EN_BIT     = 8;
    localparam int FBB_EN_BIT      = 9;
    localparam int RSVD_LO_BIT     = 10;
    localparam int RSVD_HI_BIT     = 15;

    // status field position, same dword
    localparam int DPAR_DET_BIT    = 24;

    // byte lanes (active-low enables)
    localparam int LANE_CMD_LO     = 0;
    localparam int LANE_CMD_HI     = 1;
    localparam int LANE_STAT_HI    = 3;

    // ------------------------------------------------------------
    // reset values, and the fixed wait-control value
    // ------------------------------------------------------------
    localparam logic PAL_SNOOP_RST   = 1'b0;
    localparam logic PARITY_RESP_RST = 1'b0;
    localparam logic SERR_EN_RST     = 1'b0;
    localparam logic FBB_EN_RST      = 1'b0;
    localparam logic DPAR_DET_RST    = 1'b0;
    localparam logic WAIT_CTL_VAL    = 1'b0;

    // ------------------------------------------------------------
    // palette decode
    // ------------------------------------------------------------
    localparam logic [9:0]  PAL_PORT_A  = 10'h3C6;
    localparam logic [9:0]  PAL_PORT_B  = 10'h3C8;
    localparam logic [9:0]  PAL_PORT_C  = 10'h3C9;
    localparam logic [15:0] UPPER_ZERO  = 16'h0000;

    typedef struct packed {
        logic fbb_en;
        logic serr_en;
        logic parity_resp;
        logic pal_snoop;
    } cmd_ctl_t;

    localparam cmd_ctl_t CMD_CTL_RST = '{fbb_en:      FBB_EN_RST,
                                         serr_en:     SERR_EN_RST,
                                         parity_resp: PARITY_RESP_RST,
                                         pal_snoop:   PAL_SNOOP_RST};

endpackage

// ---- design/palette_match.sv ----
// combinational palette-write address match
// assumes the caller qualifies the result with an I/O write
`timescale 1ns/1ps

module palette_match (
    input  wire logic [31:0] addr,
    output logic             hit
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic low_hit;
    logic high_ok;

    always_comb begin
        // bits 15:10 are deliberately left out of the compare
        low_hit = (addr[9:0] == cmd_upper_pkg::PAL_PORT_A) ||
                  (addr[9:0] == cmd_upper_pkg::PAL_PORT_B) ||
                  (addr[9:0] == cmd_upper_pkg::PAL_PORT_C);
        high_ok = (addr[31:16] == cmd_upper_pkg::UPPER_ZERO);
        hit     = low_hit && high_ok;
    end

endmodule // palette_match

// ---- design/cmd_upper_bank.sv ----
// upper command bits of the primary interface and their effect on
// palette claim, parity and system-error drive, fast back-to-back permit
// assumes all inputs come from primary-side logic on MCLK
`timescale 1ns/1ps

module cmd_upper_bank (
    input  wire logic        MCLK,
    input  wire logic        SYS_RST,
    input  wire logic        CFG_WR,
    input  wire logic        CFG_RD,
    input  wire logic [7:0]  CFG_ADDR,
    input  wire logic [3:0]  CFG_BE_N,
    input  wire logic [31:0] CFG_WDATA,
    output logic      [31:0] CFG_RDATA,
    output logic             CFG_RVALID,
    input  wire logic        IO_WR_REQ,
    input  wire logic [31:0] IO_ADDR,
    input  wire logic        IO_IN_RANGE,
    output logic             FWD_CLAIM,
    output logic             PAL_FWD,
    input  wire logic        IS_MASTER,
    input  wire logic        DATA_PERR_DET,
    input  wire logic        ADDR_PERR_DET,
    output logic             PERR_N_O,
    output logic             PERR_OE,
    output logic             SERR_N_O,
    output logic             SERR_OE,
    output logic             FBB_PERMIT,
    output logic             STEP_EN
);

    // ------------------------------------------------------------
    // configuration access decode
    // ------------------------------------------------------------
    logic cmd_sel;
    logic wr_cmd;
    logic rd_cmd;

    always_comb begin
        cmd_sel = (CFG_ADDR == cmd_upper_pkg::CMD_OFFSET);
        wr_cmd  = CFG_WR && cmd_sel;
        rd_cmd  = CFG_RD && cmd_sel;
    end

    // ------------------------------------------------------------
    // command control bits
    // ------------------------------------------------------------
    cmd_upper_pkg::cmd_ctl_t ctl_r;
    cmd_upper_pkg::cmd_ctl_t ctl_nxt;

    always_comb begin
        ctl_nxt = ctl_r;
        // only the lane holding each field may change it
        if (wr_cmd && !CFG_BE_N[cmd_upper_pkg::LANE_CMD_LO]) begin
            ctl_nxt.pal_snoop   = CFG_WDATA[cmd_upper_pkg::PAL_SNOOP_BIT];
            ctl_nxt.parity_resp = CFG_WDATA[cmd_upper_pkg::PARITY_RESP_BIT];
        end
        if (wr_cmd && !CFG_BE_N[cmd_upper_pkg::LANE_CMD_HI]) begin
            ctl_nxt.serr_en     = CFG_WDATA[cmd_upper_pkg::SERR_EN_BIT];
            ctl_nxt.fbb_en      = CFG_WDATA[cmd_upper_pkg::FBB_EN_BIT];
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            ctl_r <= cmd_upper_pkg::CMD_CTL_RST;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end

    // ------------------------------------------------------------
    // data parity detected status, write-one-to-clear
    // ------------------------------------------------------------
    logic dpar_r;
    logic dpar_nxt;
    logic dpar_set;
    logic dpar_clr;

    always_comb begin
        dpar_set = IS_MASTER && DATA_PERR_DET && ctl_r.parity_resp;
        dpar_clr = wr_cmd && !CFG_BE_N[cmd_upper_pkg::LANE_STAT_HI] &&
                   CFG_WDATA[cmd_upper_pkg::DPAR_DET_BIT];
        // a new error in the clearing cycle is kept
        if (dpar_set) begin
            dpar_nxt = 1'b1;
        end else if (dpar_clr) begin
            dpar_nxt = 1'b0;
        end else begin
            dpar_nxt = dpar_r;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            dpar_r <= cmd_upper_pkg::DPAR_DET_RST;
        end else begin
            dpar_r <= dpar_nxt;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic        rvalid_r;
    logic        rvalid_nxt;

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (rd_cmd) begin
            rdata_nxt[cmd_upper_pkg::PAL_SNOOP_BIT]   = ctl_r.pal_snoop;
            rdata_nxt[cmd_upper_pkg::PARITY_RESP_BIT] = ctl_r.parity_resp;
            rdata_nxt[cmd_upper_pkg::WAIT_CTL_BIT]    = cmd_upper_pkg::WAIT_CTL_VAL;
            rdata_nxt[cmd_upper_pkg::SERR_EN_BIT]     = ctl_r.serr_en;
            rdata_nxt[cmd_upper_pkg::FBB_EN_BIT]      = ctl_r.fbb_en;
            rdata_nxt[cmd_upper_pkg::DPAR_DET_BIT]    = dpar_r;
            // reserved bits 15:10 stay at the zero default
        end
        // unmapped dwords answer with zero data
        rvalid_nxt = CFG_RD;
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            rdata_r  <= cmd_upper_pkg::RDATA_RESET;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign CFG_RDATA  = rdata_r;
    assign CFG_RVALID = rvalid_r;

    // ------------------------------------------------------------
    // palette snoop claim
    // ------------------------------------------------------------
    logic pal_hit;
    logic claim_r;
    logic claim_nxt;
    logic pal_fwd_r;
    logic pal_fwd_nxt;

    palette_match u_pal (
        .addr (IO_ADDR),
        .hit  (pal_hit)
    );

    always_comb begin
        pal_fwd_nxt = IO_WR_REQ && pal_hit && ctl_r.pal_snoop;
        // with snoop off a palette write is just another I/O write
        claim_nxt   = IO_WR_REQ && (IO_IN_RANGE || pal_fwd_nxt);
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            claim_r   <= 1'b0;
            pal_fwd_r <= 1'b0;
        end else begin
            claim_r   <= claim_nxt;
            pal_fwd_r <= pal_fwd_nxt;
        end
    end

    assign FWD_CLAIM = claim_r;
    assign PAL_FWD   = pal_fwd_r;

    // ------------------------------------------------------------
    // parity and system error pin drive
    // ------------------------------------------------------------
    logic perr_drv_r;
    logic perr_drv_nxt;
    logic serr_drv_r;
    logic serr_drv_nxt;

    always_comb begin
        perr_drv_nxt = DATA_PERR_DET && ctl_r.parity_resp;
        // address parity is the only system error source here
        serr_drv_nxt = ADDR_PERR_DET && ctl_r.parity_resp && ctl_r.serr_en;
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            perr_drv_r <= 1'b0;
            serr_drv_r <= 1'b0;
        end else begin
            perr_drv_r <= perr_drv_nxt;
            serr_drv_r <= serr_drv_nxt;
        end
    end

    // pins are driven low only; the bus pull-up restores them
    assign PERR_OE  = perr_drv_r;
    assign PERR_N_O = ~perr_drv_r;
    assign SERR_OE  = serr_drv_r;
    assign SERR_N_O = ~serr_drv_r;

    // ------------------------------------------------------------
    // master-side permits
    // ------------------------------------------------------------
    assign FBB_PERMIT = ctl_r.fbb_en;
    assign STEP_EN    = cmd_upper_pkg::WAIT_CTL_VAL;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    AST_PAL_DECODE: assert property (
        IO_WR_REQ && ctl_r.pal_snoop && !IO_IN_RANGE &&
        (IO_ADDR[31:16] == 16'h0000) &&
        ((IO_ADDR[9:0] == 10'h3C6) || (IO_ADDR[9:0] == 10'h3C8) ||
         (IO_ADDR[9:0] == 10'h3C9))
        |=> FWD_CLAIM && PAL_FWD)
        else $error("palette write at a palette port was not claimed");

    AST_PAL_UPPER: assert property (
        IO_WR_REQ && (IO_ADDR[31:16] != 16'h0000) |=> !PAL_FWD)
        else $error("palette forward with nonzero upper address");

    AST_SNOOP_OFF: assert property (
        IO_WR_REQ && !ctl_r.pal_snoop && !IO_IN_RANGE |=> !FWD_CLAIM)
        else $error("claim outside range with snoop off");

    AST_SNOOP_ON: assert property (
        IO_WR_REQ && ctl_r.pal_snoop && pal_hit |=> FWD_CLAIM ##1 !FWD_CLAIM || $past(IO_WR_REQ))
        else $error("snooped palette write not claimed for one cycle");

    AST_PERR_GATE: assert property (
        !ctl_r.parity_resp |=> !PERR_OE && !($rose(dpar_r)))
        else $error("parity pin or status moved with response off");

    AST_PERR_DRIVE: assert property (
        DATA_PERR_DET && ctl_r.parity_resp |=> PERR_OE && !PERR_N_O)
        else $error("data parity error not driven on pin");

    AST_SERR_ADDR: assert property (
        ADDR_PERR_DET && ctl_r.parity_resp && ctl_r.serr_en |=> SERR_OE && !SERR_N_O)
        else $error("address parity error not reported on system error pin");

    AST_WAIT_ZERO: assert property (
        CFG_RVALID |-> !CFG_RDATA[7] && !STEP_EN)
        else $error("wait cycle bit or stepping active");

    AST_SERR_OFF: assert property (
        !ctl_r.serr_en [*2] |-> !SERR_OE)
        else $error("system error pin driven while disabled");

    AST_FBB: assert property (
        wr_cmd && !CFG_BE_N[1] |=> FBB_PERMIT == $past(CFG_WDATA[9]))
        else $error("fast back-to-back permit does not follow its bit");

    AST_FBB_HOLD: assert property (
        !(wr_cmd && !CFG_BE_N[1]) |=> $stable(FBB_PERMIT))
        else $error("fast back-to-back permit moved without a write");

    AST_RSVD_ZERO: assert property (
        CFG_RVALID |-> CFG_RDATA[15:10] == 6'h00)
        else $error("reserved command bits read nonzero");

    AST_DPAR_SET: assert property (
        $rose(dpar_r) |-> $past(IS_MASTER && DATA_PERR_DET && ctl_r.parity_resp))
        else $error("parity detected status set without cause");

    AST_DPAR_KEEP: assert property (
        dpar_set |=> dpar_r)
        else $error("parity detected status lost on a qualifying error");

    AST_LANE_MASK: assert property (
        wr_cmd && CFG_BE_N[0] |=> ctl_r.pal_snoop == $past(ctl_r.pal_snoop) &&
        ctl_r.parity_resp == $past(ctl_r.parity_resp))
        else $error("disabled byte lane changed a control bit");

    AST_LANE_MASK_HI: assert property (
        wr_cmd && CFG_BE_N[1] |=> ctl_r.serr_en == $past(ctl_r.serr_en) &&
        ctl_r.fbb_en == $past(ctl_r.fbb_en))
        else $error("disabled upper byte lane changed a control bit");

    COV_SNOOP_FWD: cover property (IO_WR_REQ && ctl_r.pal_snoop && pal_hit ##1 PAL_FWD);
    COV_PERR:      cover property (ctl_r.parity_resp && DATA_PERR_DET ##1 PERR_OE);
    COV_SERR:      cover property (ADDR_PERR_DET && ctl_r.serr_en ##1 SERR_OE);
    COV_SET_CLR:   cover property (dpar_set && dpar_clr ##1 dpar_r);

endmodule // cmd_upper_bank

// ---- testbench/primary_agent.sv ----
// primary-side agent: configuration software and primary I/O initiator
// assumes MCLK from the bench; every change lands 1 ns after a rising edge
`timescale 1ns/1ps

module primary_agent (
    input  wire logic        clk,
    output logic             cfg_wr,
    output logic             cfg_rd,
    output logic [7:0]       cfg_addr,
    output logic [3:0]       cfg_be_n,
    output logic [31:0]      cfg_wdata,
    input  wire logic [31:0] cfg_rdata,
    input  wire logic        cfg_rvalid,
    output logic             io_wr_req,
    output logic [31:0]      io_addr,
    output logic             io_in_range,
    output logic             is_master,
    output logic             data_perr,
    output logic             addr_perr
);
    initial begin
        {cfg_wr, cfg_rd, io_wr_req, io_in_range, is_master, data_perr, addr_perr} = '0;
        cfg_addr  = 8'h00;
        cfg_be_n  = 4'hF;
        cfg_wdata = 32'h0000_0000;
        io_addr   = 32'h0000_0000;
    end

    // --------------------------------------------------------
    // bus cycles
    // --------------------------------------------------------
    // released address and data lines flip to the inverse, except cfg_addr after a write, so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk) #1;
        cfg_wr    = 1'b1;
        cfg_addr  = a;
        cfg_be_n  = be;
        cfg_wdata = d;
        @(posedge clk) #1;
        cfg_wr    = 1'b0;
        cfg_be_n  = 4'hF;
        cfg_wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
        @(posedge clk) #1;
        cfg_rd   = 1'b1;
        cfg_addr = a;
        @(posedge clk) #1;
        cfg_rd   = 1'b0;
        cfg_addr = ~a;
        d        = cfg_rdata;
        v        = cfg_rvalid;
    endtask

    task automatic io(input logic [31:0] a, input logic rng);
        @(posedge clk) #1;
        io_wr_req   = 1'b1;
        io_addr     = a;
        io_in_range = rng;
        @(posedge clk) #1;
        io_wr_req   = 1'b0;
        io_addr     = ~a;
        io_in_range = 1'b0;
    endtask

    task automatic err(input logic dp, input logic ap, input logic m);
        @(posedge clk) #1;
        data_perr = dp;
        addr_perr = ap;
        is_master = m;
        @(posedge clk) #1;
        data_perr = 1'b0;
        addr_perr = 1'b0;
    endtask
endmodule // primary_agent

// ---- testbench/bridge_primary_command_upper_bits_test.sv ----
// self-checking bench for the upper command bits of the primary interface
// assumes the agent issues every bus cycle; the bench only judges outputs
`timescale 1ns/1ps

module bridge_primary_command_upper_bits_test;
    logic        mclk;
    logic        sys_rst;
    logic        cfg_wr, cfg_rd, io_wr_req, io_in_range, is_master, dperr, aperr;
    logic [7:0]  cfg_addr;
    logic [3:0]  cfg_be_n;
    logic [31:0] cfg_wdata, cfg_rdata, io_addr, rdat;
    logic        cfg_rvalid, claim, pal_fwd, perr_n, perr_oe, serr_n, serr_oe;
    logic        fbb, step, rv;
    int          err_total;
    int          tests_run;

    primary_agent i_primary_agent (.clk(mclk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_be_n(cfg_be_n), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .io_wr_req(io_wr_req),
        .io_addr(io_addr), .io_in_range(io_in_range), .is_master(is_master),
        .data_perr(dperr), .addr_perr(aperr));

    cmd_upper_bank i_cmd_upper_bank (.MCLK(mclk), .SYS_RST(sys_rst), .CFG_WR(cfg_wr),
        .CFG_RD(cfg_rd), .CFG_ADDR(cfg_addr), .CFG_BE_N(cfg_be_n), .CFG_WDATA(cfg_wdata),
        .CFG_RDATA(cfg_rdata), .CFG_RVALID(cfg_rvalid), .IO_WR_REQ(io_wr_req),
        .IO_ADDR(io_addr), .IO_IN_RANGE(io_in_range), .FWD_CLAIM(claim), .PAL_FWD(pal_fwd),
        .IS_MASTER(is_master), .DATA_PERR_DET(dperr), .ADDR_PERR_DET(aperr),
        .PERR_N_O(perr_n), .PERR_OE(perr_oe), .SERR_N_O(serr_n), .SERR_OE(serr_oe),
        .FBB_PERMIT(fbb), .STEP_EN(step));

    // --------------------------------------------------------
    // helpers
    // --------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        i_primary_agent.rd(a, rdat, rv);
        chk("rvalid", 32'h0000_0001, 32'(rv));
        chk("rdata", exp, rdat);
    endtask

    task automatic end_sim();
        if (err_total == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // --------------------------------------------------------
    // scenarios
    // --------------------------------------------------------
    task automatic t_reset();
        rd_chk(8'h04, 32'h0000_0000);
        chk("step", 32'h0, 32'(step));
        chk("fbb", 32'h0, 32'(fbb));
        chk("perr_n", 32'h1, 32'(perr_n));
        chk("serr_n", 32'h1, 32'(serr_n));
        chk("claim", 32'h0, 32'(claim));
        chk("pal_fwd", 32'h0, 32'(pal_fwd));
        chk("perr_oe", 32'h0, 32'(perr_oe));
        chk("serr_oe", 32'h0, 32'(serr_oe));
    endtask

    // lane1 held off first, so bits 8 and 9 must not move; then lane0 held off
    task automatic t_regs();
        i_primary_agent.wr(8'h04, 4'hE, 32'hFFFF_FFFF);
        rd_chk(8'h04, 32'h0000_0060);
        chk("fbb", 32'h0, 32'(fbb));
        i_primary_agent.wr(8'h04, 4'hD, 32'h0000_0000);
        rd_chk(8'h04, 32'h0000_0060);
        i_primary_agent.wr(8'h04, 4'h0, 32'hFFFF_FFFF);
        rd_chk(8'h04, 32'h0000_0360);
        chk("fbb", 32'h1, 32'(fbb));
        i_primary_agent.wr(8'h08, 4'h0, 32'h0000_0000);
        rd_chk(8'h04, 32'h0000_0360);
        rd_chk(8'h08, 32'h0000_0000);
        chk("step", 32'h0, 32'(step));
    endtask

    task automatic t_palette();
        logic [31:0] tbl [7];
        logic        hit;
        tbl = '{32'h0000_03C6, 32'h0000_03C8, 32'h0000_03C9, 32'h0000_FFC8,
                32'h0000_03C7, 32'h0001_03C6, 32'h0000_03CA};
        for (int s = 0; s < 2; s++) begin
            i_primary_agent.wr(8'h04, 4'hE, 32'(s) << 5);
            for (int r = 0; r < 2; r++) begin
                for (int i = 0; i < 7; i++) begin
                    hit = (tbl[i][9:0] == 10'h3C6 || tbl[i][9:0] == 10'h3C8
                           || tbl[i][9:0] == 10'h3C9) && tbl[i][31:16] == 16'h0000;
                    i_primary_agent.io(tbl[i], r[0]);
                    chk("claim", 32'(r[0] | (s[0] & hit)), 32'(claim));
                    chk("pal_fwd", 32'(s[0] & hit), 32'(pal_fwd));
                end
            end
        end
    endtask

    // every mix of parity response, system error enable and mastership
    task automatic t_errors();
        logic p, e, m;
        for (int k = 0; k < 8; k++) begin
            {m, e, p} = k[2:0];
            i_primary_agent.wr(8'h04, 4'h0, 32'h0100_0000 | 32'(p) << 6 | 32'(e) << 8);
            i_primary_agent.err(1'b1, 1'b0, m);
            chk("perr_oe", 32'(p), 32'(perr_oe));
            chk("perr_n", 32'(!p), 32'(perr_n));
            rd_chk(8'h04, 32'(m & p) << 24 | 32'(p) << 6 | 32'(e) << 8);
            i_primary_agent.err(1'b0, 1'b1, 1'b0);
            chk("serr_oe", 32'(p & e), 32'(serr_oe));
            chk("serr_n", 32'(!(p & e)), 32'(serr_n));
        end
    endtask

    task automatic t_rst2();
        i_primary_agent.wr(8'h04, 4'h0, 32'h0000_0360);
        @(posedge mclk) #1;
        sys_rst = 1'b1;
        repeat (2) @(posedge mclk);
        #1 sys_rst = 1'b0;
        rd_chk(8'h04, 32'h0000_0000);
        chk("fbb", 32'h0, 32'(fbb));
    endtask

    // --------------------------------------------------------
    // clock, reset, sequence, watchdog
    // --------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    initial begin
        err_total = 0;
        tests_run = 0;
        sys_rst   = 1'b1;
        repeat (2) @(posedge mclk);
        #1 sys_rst = 1'b0;
        t_reset();
        t_regs();
        t_palette();
        t_errors();
        t_rst2();
        end_sim();
    end

    // the whole sequence needs well under 1000 cycles
    initial begin
        #50000;
        err_total++;
        end_sim();
    end
endmodule // bridge_primary_command_upper_bits_test
